/* include/psac_pkg.sv */
// constants and types shared by the pump staging and auto-change controller
package psac_pkg;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS  = 40;
   localparam int TENTH_SEC_NS   = 100_000_000;
   localparam int TICK_CYCLES    = TENTH_SEC_NS / CLK_PERIOD_NS;
   localparam int TENTHS_PER_MIN = 600;

   // ----------------------------------------------------------------
   // modes and sizes
   // ----------------------------------------------------------------
   localparam logic [2:0] APP_MODE_STAGING = 3'h3;
   localparam logic [2:0] MOTOR_MAX        = 3'h4;
   localparam logic [2:0] INDEX_FIRST      = 3'h1;

   typedef enum logic [1:0] {
      ROT_NONE = 2'b00,
      ROT_AUX  = 2'b01,
      ROT_MAIN = 2'b10
   } psac_rot_t;

   typedef enum logic [1:0] {
      ST_IDLE     = 2'b00,
      ST_REGULATE = 2'b01,
      ST_RAMP_DEC = 2'b10,
      ST_RAMP_ACC = 2'b11
   } psac_st_t;

   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL       = 8'h00;
   localparam logic [7:0] OFS_STAT       = 8'h04;
   localparam logic [7:0] OFS_START_DLY  = 8'h08;
   localparam logic [7:0] OFS_STOP_DLY   = 8'h0c;
   localparam logic [7:0] OFS_WINDOW     = 8'h10;
   localparam logic [7:0] OFS_ROT_INT    = 8'h14;
   localparam logic [7:0] OFS_ACC_TIME   = 8'h18;
   localparam logic [7:0] OFS_DEC_TIME   = 8'h1c;
   localparam logic [7:0] OFS_START_FREQ = 8'h20;
   localparam logic [7:0] OFS_STOP_FREQ  = 8'h30;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CTRL_MODE_LSB  = 0;
   localparam int CTRL_ROT_LSB   = 4;
   localparam int CTRL_TOTAL_LSB = 8;
   localparam int CTRL_INDEX_LSB = 12;
   localparam int STAT_COUNT_LSB = 0;
   localparam int STAT_INDEX_LSB = 4;
   localparam int STAT_FLAG_BIT  = 8;
   localparam int STAT_RAMP_BIT  = 9;
   localparam int STAT_AUX_LSB   = 12;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [2:0]  RST_APP_MODE   = 3'h0;
   localparam logic [1:0]  RST_ROT_MODE   = 2'h0;
   localparam logic [2:0]  RST_TOTAL      = 3'h4;
   localparam logic [2:0]  RST_INDEX      = 3'h1;
   localparam logic [15:0] RST_START_FREQ = 16'h1387;
   localparam logic [15:0] RST_STOP_FREQ  = 16'h05dc;
   localparam logic [15:0] RST_DELAY      = 16'h0258;
   localparam logic [15:0] RST_WINDOW     = 16'h00c8;
   localparam logic [15:0] RST_ROT_INT    = 16'h10e0;
   localparam logic [15:0] RST_RAMP_TIME  = 16'h0014;

endpackage

/* core/psac_core.sv */
// pump staging controller with auto-change rotation and an Avalon-MM register slave
//
// Function
// R1 - staging runs only while application mode equals 3
// R2 - auxiliaries start in rotating order from the configured starting index
// R3 - auxiliaries stop in reverse start order, newest first
// R4 - running auxiliary count is readable and follows every start and stop
// R5 - next start needs main speed above that stage's start frequency
// R6 - start happens after start delay elapsed with conditions held throughout
// R7 - start also needs magnitude of PID error below the pressure window
// R8 - stop needs main speed below that stage's stop frequency
// R9 - stop happens after stop delay elapsed with conditions held throughout
// R10 - stop also needs PID error larger than the pressure window
// R11 - during a start or stop PID is suspended and a ramp drives main
// R12 - on start main ramps down to stage stop frequency over decel time
// R13 - on stop main ramps up to stage start frequency over accel time
// R14 - rotation mode 0 keeps the starting index, no rotation
// R15 - rotation mode 1 flags when run time exceeds auto-change minutes
// R16 - mode 1 advances starting index when main stops with flag set
// R17 - index advance wraps from the last motor back to motor one
// R18 - mode 2 flags when inverter-side motor run time exceeds interval
// R19 - mode 2 puts starting-index motor on inverter, others stage after it
// R20 - mode 2 stop with flag moves next motor onto inverter at restart
// R21 - auxiliaries driven on two relays, one multi-function output, expansion relay
// R22 - rotation clears the run-time counter and the rotation flag
// R23 - one transition at a time; delay timers restart after each one
`timescale 1ns/1ps
`default_nettype none

module psac_core
   import psac_pkg::*;
#(
   parameter int TICK_CYCLES_P = TICK_CYCLES
) (
   input  wire logic        REF_CLK,
   input  wire logic        RESETN,
   input  wire logic [7:0]  ADDRESS,
   input  wire logic        READ,
   input  wire logic        WRITE,
   input  wire logic [31:0] WRITEDATA,
   input  wire logic [3:0]  BYTEENABLE,
   output logic      [31:0] READDATA,
   output logic             WAITREQUEST,
   input  wire logic [15:0] MAIN_FREQ,
   input  wire logic [15:0] PID_ERR,
   input  wire logic        DRIVE_RUN,
   output logic      [3:0]  AUX_OUT,
   output logic      [3:0]  MAIN_SEL,
   output logic             PID_SUSPEND,
   output logic      [15:0] RAMP_TARGET,
   output logic      [15:0] RAMP_TIME,
   output logic             RAMP_ACCEL
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [15:0] psac_merge(input logic [15:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0]  be);
      logic [15:0] r;
      r = old;
      if (be[0]) r[7:0] = wd[7:0];
      if (be[1]) r[15:8] = wd[15:8];
      return r;
   endfunction

   // slot of the motor at position off of the order that begins at first
   function automatic logic [1:0] psac_slot(input logic [2:0] first,
                                            input logic [2:0] off,
                                            input logic [2:0] n);
      logic [3:0] v;
      v = {1'b0, first} - 4'h1 + {1'b0, off};
      for (int i = 0; i < 8; i++) begin
         if (n != 3'h0 && v >= {1'b0, n}) v = v - {1'b0, n};
      end
      return v[1:0];
   endfunction

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [2:0]  app_mode;
   psac_rot_t   rotation_mode;
   logic [2:0]  aux_motor_total;
   logic [2:0]  starting_aux_index;
   logic [15:0] aux_start_delay;
   logic [15:0] aux_stop_delay;
   logic [15:0] pressure_diff_window;
   logic [15:0] rotation_interval;
   logic [15:0] acc_time;
   logic [15:0] dec_time;
   logic [15:0] start_freq [4];
   logic [15:0] stop_freq  [4];
   logic        wait_q;
   logic        wr_en;
   logic [31:0] next_readdata;
   psac_st_t    st;
   logic [2:0]  running_aux_count;
   logic [15:0] start_tmr;
   logic [15:0] stop_tmr;
   logic        rot_flag;
   logic [9:0]  tenths;
   logic [15:0] minutes;
   logic        run_q;

   // ----------------------------------------------------------------
   // derived terms
   // ----------------------------------------------------------------
   localparam int TW = $clog2(TICK_CYCLES_P + 1);
   localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES_P - 1);
   logic [TW-1:0] pre;
   logic          tick;
   logic        active;
   logic        mode_main;
   logic [2:0]  n_mot;
   logic [2:0]  first;
   logic [2:0]  max_aux;
   logic [2:0]  base_off;
   logic [15:0] err_mag;
   logic [1:0]  stage;
   logic [1:0]  top;
   logic        start_cond;
   logic        stop_cond;
   logic        rot_event;
   logic [2:0]  next_index;

   assign active    = (app_mode == APP_MODE_STAGING) && DRIVE_RUN;  // see R1
   assign mode_main = (rotation_mode == ROT_MAIN);
   assign n_mot     = (aux_motor_total > MOTOR_MAX) ? MOTOR_MAX : aux_motor_total;
   assign first     = (starting_aux_index == 3'h0 || starting_aux_index > n_mot) ?
                      INDEX_FIRST : starting_aux_index;
   // in mode 2 the first motor of the order sits on the inverter
   assign base_off  = mode_main ? 3'h1 : 3'h0;  // see R19
   assign max_aux   = (mode_main && n_mot != 3'h0) ? n_mot - 3'h1 : n_mot;
   assign err_mag   = PID_ERR[15] ? 16'(-PID_ERR) : PID_ERR;
   assign stage     = running_aux_count[1:0];
   assign top       = 2'(running_aux_count - 3'h1);

   assign start_cond = (st == ST_REGULATE) && (running_aux_count < max_aux)
                       && (MAIN_FREQ > start_freq[stage])            // see R5
                       && (err_mag < pressure_diff_window);          // see R7
   assign stop_cond  = (st == ST_REGULATE) && (running_aux_count != 3'h0)
                       && (MAIN_FREQ < stop_freq[top])               // see R8
                       && (err_mag > pressure_diff_window);          // see R10

   assign rot_event  = run_q && !DRIVE_RUN && rot_flag && (app_mode == APP_MODE_STAGING)
                       && (rotation_mode == ROT_AUX || mode_main);   // see R16 see R20
   assign next_index = (first >= n_mot) ? INDEX_FIRST : first + 3'h1;  // see R17

   // ----------------------------------------------------------------
   // bus slave: one wait cycle on every access
   // ----------------------------------------------------------------
   assign wr_en = WRITE && !wait_q;

   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         wait_q <= 1'b1;
      end else if (!wait_q) begin
         wait_q <= 1'b1;
      end else if (READ || WRITE) begin
         wait_q <= 1'b0;
      end
   end

   always_comb begin
      next_readdata = 32'h0;
      case (ADDRESS)
         OFS_CTRL: begin
            next_readdata[CTRL_MODE_LSB +: 3]  = app_mode;
            next_readdata[CTRL_ROT_LSB +: 2]   = rotation_mode;
            next_readdata[CTRL_TOTAL_LSB +: 3] = aux_motor_total;
            next_readdata[CTRL_INDEX_LSB +: 3] = starting_aux_index;
         end
         OFS_STAT: begin
            next_readdata[STAT_COUNT_LSB +: 3] = running_aux_count;  // see R4
            next_readdata[STAT_INDEX_LSB +: 3] = first;
            next_readdata[STAT_FLAG_BIT]       = rot_flag;
            next_readdata[STAT_RAMP_BIT]       = PID_SUSPEND;
            next_readdata[STAT_AUX_LSB +: 4]   = AUX_OUT;
         end
         OFS_START_DLY: next_readdata[15:0] = aux_start_delay;
         OFS_STOP_DLY:  next_readdata[15:0] = aux_stop_delay;
         OFS_WINDOW:    next_readdata[15:0] = pressure_diff_window;
         OFS_ROT_INT:   next_readdata[15:0] = rotation_interval;
         OFS_ACC_TIME:  next_readdata[15:0] = acc_time;
         OFS_DEC_TIME:  next_readdata[15:0] = dec_time;
         default: begin
            if (ADDRESS[7:4] == OFS_START_FREQ[7:4] && ADDRESS[1:0] == 2'h0) begin
               next_readdata[15:0] = start_freq[ADDRESS[3:2]];
            end else if (ADDRESS[7:4] == OFS_STOP_FREQ[7:4] && ADDRESS[1:0] == 2'h0) begin
               next_readdata[15:0] = stop_freq[ADDRESS[3:2]];
            end
         end
      endcase
   end

   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         READDATA <= 32'h0;
      end else if (READ && wait_q) begin
         READDATA <= next_readdata;
      end
   end

   assign WAITREQUEST = wait_q;

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         app_mode             <= RST_APP_MODE;
         rotation_mode        <= psac_rot_t'(RST_ROT_MODE);
         aux_motor_total      <= RST_TOTAL;
         starting_aux_index   <= RST_INDEX;
         aux_start_delay      <= RST_DELAY;
         aux_stop_delay       <= RST_DELAY;
         pressure_diff_window <= RST_WINDOW;
         rotation_interval    <= RST_ROT_INT;
         acc_time             <= RST_RAMP_TIME;
         dec_time             <= RST_RAMP_TIME;
         for (int i = 0; i < 4; i++) begin
            start_freq[i] <= RST_START_FREQ;
            stop_freq[i]  <= RST_STOP_FREQ;
         end
      end else if (wr_en && ADDRESS == OFS_CTRL) begin
         if (BYTEENABLE[0]) begin
            app_mode      <= WRITEDATA[CTRL_MODE_LSB +: 3];
            rotation_mode <= psac_rot_t'(WRITEDATA[CTRL_ROT_LSB +: 2]);
         end
         if (BYTEENABLE[1]) begin
            aux_motor_total    <= WRITEDATA[CTRL_TOTAL_LSB +: 3];
            starting_aux_index <= WRITEDATA[CTRL_INDEX_LSB +: 3];
         end
      end else if (rot_event) begin
         starting_aux_index <= next_index;  // see R16 see R20
      end else if (wr_en) begin
         case (ADDRESS)
            OFS_START_DLY: aux_start_delay      <= psac_merge(aux_start_delay, WRITEDATA, BYTEENABLE);
            OFS_STOP_DLY:  aux_stop_delay       <= psac_merge(aux_stop_delay, WRITEDATA, BYTEENABLE);
            OFS_WINDOW:    pressure_diff_window <= psac_merge(pressure_diff_window, WRITEDATA, BYTEENABLE);
            OFS_ROT_INT:   rotation_interval    <= psac_merge(rotation_interval, WRITEDATA, BYTEENABLE);
            OFS_ACC_TIME:  acc_time             <= psac_merge(acc_time, WRITEDATA, BYTEENABLE);
            OFS_DEC_TIME:  dec_time             <= psac_merge(dec_time, WRITEDATA, BYTEENABLE);
            default: begin
               if (ADDRESS[7:4] == OFS_START_FREQ[7:4] && ADDRESS[1:0] == 2'h0) begin
                  start_freq[ADDRESS[3:2]] <= psac_merge(start_freq[ADDRESS[3:2]], WRITEDATA, BYTEENABLE);
               end else if (ADDRESS[7:4] == OFS_STOP_FREQ[7:4] && ADDRESS[1:0] == 2'h0) begin
                  stop_freq[ADDRESS[3:2]] <= psac_merge(stop_freq[ADDRESS[3:2]], WRITEDATA, BYTEENABLE);
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // tenth-of-a-second tick
   // ----------------------------------------------------------------
   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         pre  <= '0;
         tick <= 1'b0;
      end else if (pre == TICK_LAST) begin
         pre  <= '0;
         tick <= 1'b1;
      end else begin
         pre  <= pre + 1'b1;
         tick <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // staging delay timers
   // ----------------------------------------------------------------
   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         start_tmr <= 16'h0;
         stop_tmr  <= 16'h0;
      end else begin
         // a lapse of the conditions or any ramp restarts the timer
         if (!start_cond) begin
            start_tmr <= 16'h0;  // see R6 see R23
         end else if (tick && start_tmr != 16'hffff) begin
            start_tmr <= start_tmr + 16'h1;
         end
         if (!stop_cond || start_cond) begin
            stop_tmr <= 16'h0;  // see R9 see R23
         end else if (tick && stop_tmr != 16'hffff) begin
            stop_tmr <= stop_tmr + 16'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // staging state machine and outputs
   // ----------------------------------------------------------------
   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         st                <= ST_IDLE;
         running_aux_count <= 3'h0;
         AUX_OUT           <= 4'h0;
         PID_SUSPEND       <= 1'b0;
         RAMP_TARGET       <= 16'h0;
         RAMP_TIME         <= 16'h0;
         RAMP_ACCEL        <= 1'b0;
      end else if (!active) begin
         st                <= ST_IDLE;  // see R1
         running_aux_count <= 3'h0;
         AUX_OUT           <= 4'h0;
         PID_SUSPEND       <= 1'b0;
      end else begin
         case (st)
            ST_IDLE: begin
               st <= ST_REGULATE;
            end
            ST_REGULATE: begin
               if (start_cond && start_tmr >= aux_start_delay) begin
                  // see R2 see R21
                  AUX_OUT[psac_slot(first, running_aux_count + base_off, n_mot)] <= 1'b1;
                  running_aux_count <= running_aux_count + 3'h1;  // see R4
                  PID_SUSPEND       <= 1'b1;                      // see R11
                  RAMP_TARGET       <= stop_freq[stage];          // see R12
                  RAMP_TIME         <= dec_time;
                  RAMP_ACCEL        <= 1'b0;
                  st                <= ST_RAMP_DEC;
               end else if (stop_cond && stop_tmr >= aux_stop_delay) begin
                  // see R3
                  AUX_OUT[psac_slot(first, 3'(running_aux_count - 3'h1 + base_off), n_mot)] <= 1'b0;
                  running_aux_count <= running_aux_count - 3'h1;  // see R4
                  PID_SUSPEND       <= 1'b1;                      // see R11
                  RAMP_TARGET       <= start_freq[top];           // see R13
                  RAMP_TIME         <= acc_time;
                  RAMP_ACCEL        <= 1'b1;
                  st                <= ST_RAMP_ACC;
               end
            end
            ST_RAMP_DEC, ST_RAMP_ACC: begin
               if (RAMP_ACCEL ? (MAIN_FREQ >= RAMP_TARGET) : (MAIN_FREQ <= RAMP_TARGET)) begin
                  PID_SUSPEND <= 1'b0;
                  st          <= ST_REGULATE;
               end
            end
            default: begin
               st <= ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // inverter-side motor selection
   // ----------------------------------------------------------------
   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         MAIN_SEL <= 4'h0;
      end else if (mode_main && app_mode == APP_MODE_STAGING && n_mot != 3'h0) begin
         MAIN_SEL <= 4'h1 << psac_slot(first, 3'h0, n_mot);  // see R19
      end else begin
         MAIN_SEL <= 4'h0;
      end
   end

   // ----------------------------------------------------------------
   // run time and rotation flag
   // ----------------------------------------------------------------
   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         run_q    <= 1'b0;
         tenths   <= 10'h0;
         minutes  <= 16'h0;
         rot_flag <= 1'b0;
      end else begin
         run_q <= DRIVE_RUN;
         if (rot_event) begin
            tenths  <= 10'h0;  // see R22
            minutes <= 16'h0;
         end else if (tick && active) begin
            if (tenths == 10'(TENTHS_PER_MIN - 1)) begin
               tenths <= 10'h0;
               if (minutes != 16'hffff) minutes <= minutes + 16'h1;
            end else begin
               tenths <= tenths + 10'h1;
            end
         end
         // a rotation restarts the count, so the old count sets nothing then
         if ((rotation_mode == ROT_AUX || mode_main) && !rot_event
             && minutes > rotation_interval) begin
            rot_flag <= 1'b1;  // see R15 see R18
         end else if (rot_event || rotation_mode == ROT_NONE) begin
            rot_flag <= 1'b0;  // see R14 see R22
         end
      end
   end

endmodule // psac_core

`default_nettype wire

/* bench/psac_checker_assertions.sv */
// concurrent checks on the staging controller ports
`timescale 1ns/1ps
`default_nettype none
module psac_checker (
   input wire logic        REF_CLK,
   input wire logic        RESETN,
   input wire logic        READ,
   input wire logic        WRITE,
   input wire logic        WAITREQUEST,
   input wire logic [15:0] MAIN_FREQ,
   input wire logic        DRIVE_RUN,
   input wire logic [3:0]  AUX_OUT,
   input wire logic [3:0]  MAIN_SEL,
   input wire logic        PID_SUSPEND,
   input wire logic [15:0] RAMP_TARGET,
   input wire logic        RAMP_ACCEL
);
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RESETN);
   sequence s_run;
      DRIVE_RUN && $past(DRIVE_RUN);
   endsequence
   sequence s_up;
      s_run ##0 ($countones(AUX_OUT) > $countones($past(AUX_OUT)));
   endsequence
   sequence s_down;
      s_run ##0 ($countones(AUX_OUT) < $countones($past(AUX_OUT)));
   endsequence
   a_idle_clears: assert property (!DRIVE_RUN |=> AUX_OUT == 4'h0)
      else $error("relays still on while drive stopped");
   a_single_step: assert property (s_run |-> $countones(AUX_OUT ^ $past(AUX_OUT)) <= 1)
      else $error("more than one relay changed at once");
   a_step_suspends: assert property (s_run ##0 (AUX_OUT != $past(AUX_OUT)) |-> PID_SUSPEND)
      else $error("relay change without regulation suspended");
   a_start_decel: assert property (s_up |-> !RAMP_ACCEL)
      else $error("start did not choose deceleration");
   a_stop_accel: assert property (s_down |-> RAMP_ACCEL)
      else $error("stop did not choose acceleration");
   a_ramp_release: assert property (PID_SUSPEND && !RAMP_ACCEL && MAIN_FREQ <= RAMP_TARGET
      |=> !PID_SUSPEND)
      else $error("regulation not resumed at ramp target");
   a_ramp_hold: assert property (PID_SUSPEND && DRIVE_RUN |=> $stable(AUX_OUT))
      else $error("relay changed during ramp");
   a_inverter_excl: assert property ($onehot0(MAIN_SEL) && (MAIN_SEL & AUX_OUT) == 4'h0)
      else $error("inverter motor also on line relay");
   a_wait_pulse: assert property (!WAITREQUEST |=> WAITREQUEST)
      else $error("waitrequest low longer than one cycle");
   a_bus_answer: assert property ((READ || WRITE) && WAITREQUEST |=> !WAITREQUEST)
      else $error("bus request not answered");
endmodule // psac_checker
bind psac_core psac_checker u_chk (.REF_CLK(REF_CLK), .RESETN(RESETN), .READ(READ),
   .WRITE(WRITE), .WAITREQUEST(WAITREQUEST), .MAIN_FREQ(MAIN_FREQ), .DRIVE_RUN(DRIVE_RUN),
   .AUX_OUT(AUX_OUT), .MAIN_SEL(MAIN_SEL), .PID_SUSPEND(PID_SUSPEND),
   .RAMP_TARGET(RAMP_TARGET), .RAMP_ACCEL(RAMP_ACCEL));
`default_nettype wire

/* bench/psac_contactor.sv */
// contactor bank model: each contact follows its relay coil two cycles later
`timescale 1ns/1ps
`default_nettype none
module psac_contactor (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic [3:0] coil,
   output logic      [3:0] contact
);
   logic [3:0] pick;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pick <= 4'h0;
         contact <= 4'h0;
      end else begin
         pick <= coil;
         contact <= pick;
      end
   end
endmodule // psac_contactor
`default_nettype wire

/* bench/psac_core_bench.sv */
// self-checking bench for the pump staging controller
`timescale 1ns/1ps
`default_nettype none
module psac_core_bench;
   import psac_pkg::*;
   logic        REF_CLK = 1'b0;
   logic        RESETN = 1'b0;
   logic [7:0]  ADDRESS = 8'h00;
   logic        READ = 1'b0;
   logic        WRITE = 1'b0;
   logic [31:0] WRITEDATA = 32'h0;
   logic [15:0] MAIN_FREQ = 16'h0;
   logic [15:0] PID_ERR = 16'h12c;
   logic        DRIVE_RUN = 1'b0;
   logic [15:0] freq_cmd = 16'd5500;
   logic [3:0]  last = 4'h0;
   logic [31:0] READDATA, rd;
   logic        WAITREQUEST, PID_SUSPEND, RAMP_ACCEL;
   logic [3:0]  AUX_OUT, MAIN_SEL, contact;
   logic [15:0] RAMP_TARGET, RAMP_TIME;
   logic [3:0]  exp_q[$];
   logic [7:0]  ofs[8] = '{8'h00, 8'h08, 8'h10, 8'h14, 8'h1c, 8'h2c, 8'h3c, 8'h40};
   logic [15:0] want[8] = '{16'h1400, 16'h0258, 16'h00c8, 16'h10e0, 16'h0014, 16'h1387,
                            16'h05dc, 16'h0000};
   int          n_errors = 0;
   int          cmp_count = 0;
   always #20 REF_CLK = ~REF_CLK;
   psac_core #(.TICK_CYCLES_P(4)) DUT (.REF_CLK(REF_CLK), .RESETN(RESETN), .ADDRESS(ADDRESS),
      .READ(READ), .WRITE(WRITE), .WRITEDATA(WRITEDATA), .BYTEENABLE(4'hf),
      .READDATA(READDATA), .WAITREQUEST(WAITREQUEST), .MAIN_FREQ(MAIN_FREQ),
      .PID_ERR(PID_ERR), .DRIVE_RUN(DRIVE_RUN), .AUX_OUT(AUX_OUT), .MAIN_SEL(MAIN_SEL),
      .PID_SUSPEND(PID_SUSPEND), .RAMP_TARGET(RAMP_TARGET), .RAMP_TIME(RAMP_TIME),
      .RAMP_ACCEL(RAMP_ACCEL));
   psac_contactor u_relays (.clk(REF_CLK), .rst_n(RESETN), .coil(AUX_OUT), .contact(contact));
   // main motor follows the staging ramp, else the pressure loop speed
   always @(posedge REF_CLK) MAIN_FREQ <= PID_SUSPEND ? RAMP_TARGET : freq_cmd;
   always @(posedge REF_CLK) begin
      last <= contact;
      if (RESETN && contact !== last) begin
         if (exp_q.size() == 0)
            chk({28'h0, contact}, {28'h0, last});
         else
            chk({28'h0, contact}, {28'h0, exp_q.pop_front()});
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
         n_errors++;
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      ADDRESS <= a;
      WRITEDATA <= d;
      WRITE <= w;
      READ <= ~w;
      do begin
         @(posedge REF_CLK);
      end while (WAITREQUEST !== 1'b0);
      rd = READDATA;
      WRITE <= 1'b0;
      READ <= 1'b0;
      @(posedge REF_CLK);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rd & m, e);
   endtask
   task automatic settle(input int left);
      while (exp_q.size() > left || PID_SUSPEND !== 1'b0) @(posedge REF_CLK);
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge REF_CLK);
      n_errors++;
      final_report();
   end
   initial begin
      void'($urandom(32'h32bfffe4));
      repeat (10) @(posedge REF_CLK);
      RESETN <= 1'b1;
      @(posedge REF_CLK);
      for (int i = 0; i < 8; i++) rdchk(ofs[i], 32'hffffffff, {16'h0, want[i]});
      DRIVE_RUN <= 1'b1;
      repeat (40) @(posedge REF_CLK);
      chk({28'h0, AUX_OUT}, 32'h0);
      DRIVE_RUN <= 1'b0;
      bus(1'b1, OFS_START_DLY, 32'h2);
      bus(1'b1, OFS_STOP_DLY, 32'h2);
      bus(1'b1, OFS_DEC_TIME, 32'h1e);
      bus(1'b1, OFS_CTRL, 32'h2303);
      DRIVE_RUN <= 1'b1;
      repeat (60) @(posedge REF_CLK);
      exp_q = '{4'h2, 4'h6, 4'h7};
      PID_ERR <= 16'($urandom_range(199));
      settle(0);
      rdchk(OFS_STAT, 32'h7, 32'h3);
      chk({RAMP_TARGET, RAMP_TIME}, {RST_STOP_FREQ, 16'h001e});
      freq_cmd <= 16'd1000;
      repeat (60) @(posedge REF_CLK);
      exp_q = '{4'h6, 4'h2, 4'h0};
      PID_ERR <= 16'($urandom_range(1000, 201));
      settle(0);
      rdchk(OFS_STAT, 32'h7, 32'h0);
      chk({RAMP_TARGET, RAMP_TIME}, {RST_START_FREQ, RST_RAMP_TIME});
      DRIVE_RUN <= 1'b0;
      bus(1'b1, OFS_ROT_INT, 32'h0);
      bus(1'b1, OFS_CTRL, 32'h4413);
      DRIVE_RUN <= 1'b1;
      repeat (2600) @(posedge REF_CLK);
      rdchk(OFS_STAT, 32'h170, 32'h140);
      DRIVE_RUN <= 1'b0;
      repeat (4) @(posedge REF_CLK);
      rdchk(OFS_STAT, 32'h170, 32'h010);
      bus(1'b1, OFS_CTRL, 32'h2423);
      freq_cmd <= 16'd5500;
      PID_ERR <= 16'($urandom_range(199));
      DRIVE_RUN <= 1'b1;
      exp_q = '{4'h4, 4'hc, 4'hd};
      repeat (4) @(posedge REF_CLK);
      chk({28'h0, MAIN_SEL}, 32'h2);
      settle(0);
      exp_q.push_back(4'h0);
      DRIVE_RUN <= 1'b0;
      repeat (8) @(posedge REF_CLK);
      chk(exp_q.size(), 32'h0);
      final_report();
   end
endmodule // psac_core_bench
`default_nettype wire
